// ==== hdl/pacc_consts.vh ====
// Constants for the pulse accumulator: offsets, fields, resets, timing
`ifndef PACC_CONSTS_VH
`define PACC_CONSTS_VH

`define PACC_ADDR_W        6
`define PACC_OFF_CTRL      6'h20
`define PACC_OFF_FLAGS     6'h21
`define PACC_OFF_CNT_HI    6'h22
`define PACC_OFF_CNT_LO    6'h23

`define PACC_CTRL_ENABLE   6
`define PACC_CTRL_MODE     5
`define PACC_CTRL_EDGE     4
`define PACC_CTRL_CLK_HI   3
`define PACC_CTRL_CLK_LO   2
`define PACC_CTRL_OVF_IE   1
`define PACC_CTRL_IN_IE    0

`define PACC_FLG_OVF       1
`define PACC_FLG_IN        0

`define PACC_CTRL_RESET    8'h00
`define PACC_FLAGS_RESET   8'h00
`define PACC_COUNT_RESET   16'h0000

`define PACC_GATE_DIV      64
`define PACC_DIV_256_W     8
`define PACC_DIV_64K_W     16

`define PACC_CLK_PRESCALE  2'h0
`define PACC_CLK_PULSE     2'h1
`define PACC_CLK_PULSE_256 2'h2
`define PACC_CLK_PULSE_64K 2'h3

`endif

// ==== hdl/pacc_edge_sync.v ====
// Pin synchroniser and edge detector for the shared channel seven pin
module pacc_edge_sync
(
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire pin_in,
  output reg  level_out,
  output wire rise_out,
  output wire fall_out
);

  reg meta_reg;
  reg sync_reg;

  // --------------------------------------------------------------
  // Two-stage synchroniser then edge detect
  // --------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg  <= 1'b0;
      sync_reg  <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      meta_reg  <= pin_in;
      sync_reg  <= meta_reg;
      level_out <= sync_reg;
    end
  end

  assign rise_out = sync_reg & ~level_out;
  assign fall_out = ~sync_reg & level_out;

endmodule

// ==== hdl/pacc_top.v ====
// Sixteen-bit pulse accumulator with register port and timer clock select
//
// Overview of operation
// - Enable bit 6 counts channel seven pin
// - Event-mode pulse counter runs independent of timer enable
// - Mode bit 5: event or gated
// - Event mode: edge bit picks falling/rising
// - Gated: div64 clock while pin active level
// - Div64 tick comes from prescaler, needs timer
// - Clock select picks timer counter clock source
// - Disabled counter forces prescaler clock select
// - Clock source switch acts immediately
// - Overflow flag and enable request interrupt
// - Input flag and enable request interrupt
// - Overflow flag set on 0xffff wrap
// - Input flag on event or gate trailing edge
// - Write-one clears flag while any enabled
// - Fast clear: count access clears flags
// - Sixteen-bit count, readable writable anytime
// - Pin synchronised before counting
`include "pacc_consts.vh"

module pacc_top
#(
  parameter CNT_W = 16
)
(
  input  wire                     SYS_CLK_IN,
  input  wire                     RST_N_IN,
  input  wire [`PACC_ADDR_W-1:0]  ADDR_IN,
  input  wire [7:0]               WDATA_IN,
  input  wire                     WR_IN,
  input  wire                     RD_IN,
  input  wire                     WORD_IN,
  output reg  [15:0]              RDATA_OUT,
  input  wire                     CHANNEL_SEVEN_PIN_IN,
  input  wire                     MAIN_TIMER_ENABLE_IN,
  input  wire                     FAST_FLAG_CLEAR_IN,
  input  wire                     PRESCALER_TICK_IN,
  input  wire                     PRESCALER_DIV64_TICK_IN,
  output wire                     TIMER_COUNTER_TICK_OUT,
  output wire                     PULSE_COUNTER_CLOCK_OUT,
  output wire                     OVERFLOW_IRQ_OUT,
  output wire                     INPUT_EDGE_IRQ_OUT
);

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  reg  [7:0]        ctrl_reg;
  reg  [7:0]        ctrl_next;
  reg               ovf_flag_reg;
  reg               ovf_flag_next;
  reg               in_flag_reg;
  reg               in_flag_next;
  reg  [CNT_W-1:0]  count_reg;
  reg  [CNT_W-1:0]  count_next;
  reg  [7:0]        div256_reg;
  reg  [7:0]        div256_next;
  reg  [7:0]        div64k_reg;
  reg  [7:0]        div64k_next;
  reg  [15:0]       rdata_next;

  wire              pin_level;
  wire              pin_rise;
  wire              pin_fall;
  wire              pulse_count_enable;
  wire              count_mode_select;
  wire              edge_polarity_select;
  wire [1:0]        clk_sel;
  wire              event_edge;
  wire              gate_active;
  wire              gate_trailing;
  wire              gate_tick;
  wire              pulse_tick;
  wire              count_wrap;
  wire              any_enable;
  wire              wr_ctrl;
  wire              wr_flags;
  wire              wr_hi;
  wire              wr_lo;
  wire              count_access;
  wire              div256_tick;
  wire              div64k_tick;
  reg               timer_tick;

  // --------------------------------------------------------------
  // Address decode helper
  // --------------------------------------------------------------
  function hit;
    input [`PACC_ADDR_W-1:0] addr;
    input [`PACC_ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // --------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------
  pacc_edge_sync u_sync
  (
    .clk_in    (SYS_CLK_IN),
    .rst_n_in  (RST_N_IN),
    .pin_in    (CHANNEL_SEVEN_PIN_IN),
    .level_out (pin_level),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  // --------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------
  assign pulse_count_enable   = ctrl_reg[`PACC_CTRL_ENABLE];
  assign count_mode_select    = ctrl_reg[`PACC_CTRL_MODE];
  assign edge_polarity_select = ctrl_reg[`PACC_CTRL_EDGE];
  assign clk_sel = ctrl_reg[`PACC_CTRL_CLK_HI:`PACC_CTRL_CLK_LO];

  // --------------------------------------------------------------
  // Counting events
  // --------------------------------------------------------------
  assign event_edge    = edge_polarity_select ? pin_rise : pin_fall;
  assign gate_active   = edge_polarity_select ? ~pin_level : pin_level;
  assign gate_trailing = edge_polarity_select ? pin_rise : pin_fall;
  assign gate_tick = MAIN_TIMER_ENABLE_IN & PRESCALER_DIV64_TICK_IN & gate_active;

  assign pulse_tick = pulse_count_enable &
                      (count_mode_select ? gate_tick : event_edge);
  assign PULSE_COUNTER_CLOCK_OUT = pulse_tick;

  // --------------------------------------------------------------
  // Register port decode
  // --------------------------------------------------------------
  function count_hit;
    input [`PACC_ADDR_W-1:0] addr;
    begin
      count_hit = hit(addr, `PACC_OFF_CNT_HI) | hit(addr, `PACC_OFF_CNT_LO);
    end
  endfunction

  assign wr_ctrl  = WR_IN & hit(ADDR_IN, `PACC_OFF_CTRL);
  assign wr_flags = WR_IN & hit(ADDR_IN, `PACC_OFF_FLAGS);
  // Word write loads the high byte, low byte keeps
  assign wr_hi    = WR_IN & hit(ADDR_IN, `PACC_OFF_CNT_HI);
  assign wr_lo    = WR_IN & hit(ADDR_IN, `PACC_OFF_CNT_LO) & ~WORD_IN;
  assign count_access = (WR_IN | RD_IN) & count_hit(ADDR_IN);

  assign count_wrap = pulse_tick & (count_reg == {CNT_W{1'b1}});
  assign any_enable = MAIN_TIMER_ENABLE_IN | pulse_count_enable;

  // --------------------------------------------------------------
  // Control register next value
  // --------------------------------------------------------------
  always @*
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
      ctrl_next = {1'b0, WDATA_IN[6:0]};
  end

  // --------------------------------------------------------------
  // Count register next value
  // --------------------------------------------------------------
  always @*
  begin
    count_next = count_reg;
    if (pulse_tick)
      count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    if (wr_hi)
      count_next[15:8] = WDATA_IN;
    if (wr_lo)
      count_next[7:0] = WDATA_IN;
  end

  // --------------------------------------------------------------
  // Flag next values
  // --------------------------------------------------------------
  // Hardware set wins over a same-cycle clear
  always @*
  begin
    ovf_flag_next = ovf_flag_reg;
    if (wr_flags && any_enable && WDATA_IN[`PACC_FLG_OVF])
      ovf_flag_next = 1'b0;
    if (FAST_FLAG_CLEAR_IN && count_access)
      ovf_flag_next = 1'b0;
    if (count_wrap)
      ovf_flag_next = 1'b1;
  end

  always @*
  begin
    in_flag_next = in_flag_reg;
    if (wr_flags && any_enable && WDATA_IN[`PACC_FLG_IN])
      in_flag_next = 1'b0;
    if (FAST_FLAG_CLEAR_IN && count_access)
      in_flag_next = 1'b0;
    if (pulse_count_enable && (count_mode_select ? gate_trailing : event_edge))
      in_flag_next = 1'b1;
  end

  // --------------------------------------------------------------
  // Read data next value
  // --------------------------------------------------------------
  always @*
  begin
    rdata_next = 16'h0000;
    if (RD_IN)
    begin
      case (ADDR_IN)
        `PACC_OFF_CTRL:   rdata_next = {8'h00, ctrl_reg};
        `PACC_OFF_FLAGS:  rdata_next = {14'h0000, ovf_flag_reg, in_flag_reg};
        `PACC_OFF_CNT_HI: rdata_next = WORD_IN ? count_reg : {8'h00, count_reg[15:8]};
        `PACC_OFF_CNT_LO: rdata_next = {8'h00, count_reg[7:0]};
        default:          rdata_next = 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Timer counter clock dividers
  // --------------------------------------------------------------
  function [7:0] inc8;
    input [7:0] value;
    begin
      inc8 = value + 8'h01;
    end
  endfunction

  assign div256_tick = pulse_tick & (div256_reg == 8'hff);
  assign div64k_tick = div256_tick & (div64k_reg == 8'hff);

  always @*
  begin
    if (pulse_tick)
      div256_next = inc8(div256_reg);
    else
      div256_next = div256_reg;
  end

  always @*
  begin
    if (div256_tick)
      div64k_next = inc8(div64k_reg);
    else
      div64k_next = div64k_reg;
  end

  // --------------------------------------------------------------
  // Timer counter clock select
  // --------------------------------------------------------------
  // Combinational select so a new source acts at once
  always @*
  begin
    if (!pulse_count_enable)
      timer_tick = PRESCALER_TICK_IN;
    else
    begin
      case (clk_sel)
        `PACC_CLK_PRESCALE:  timer_tick = PRESCALER_TICK_IN;
        `PACC_CLK_PULSE:     timer_tick = pulse_tick;
        `PACC_CLK_PULSE_256: timer_tick = div256_tick;
        `PACC_CLK_PULSE_64K: timer_tick = div64k_tick;
        default:             timer_tick = PRESCALER_TICK_IN;
      endcase
    end
  end
  assign TIMER_COUNTER_TICK_OUT = timer_tick;

  // --------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------
  always @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_reg <= `PACC_CTRL_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // --------------------------------------------------------------
  // Flag registers
  // --------------------------------------------------------------
  always @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      ovf_flag_reg <= 1'b0;
      in_flag_reg  <= 1'b0;
    end
    else
    begin
      ovf_flag_reg <= ovf_flag_next;
      in_flag_reg  <= in_flag_next;
    end
  end

  // --------------------------------------------------------------
  // Count register
  // --------------------------------------------------------------
  always @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      count_reg <= `PACC_COUNT_RESET;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // --------------------------------------------------------------
  // Divider registers
  // --------------------------------------------------------------
  always @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      div256_reg <= 8'h00;
      div64k_reg <= 8'h00;
    end
    else
    begin
      div256_reg <= div256_next;
      div64k_reg <= div64k_next;
    end
  end

  // --------------------------------------------------------------
  // Read data register
  // --------------------------------------------------------------
  always @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      RDATA_OUT <= 16'h0000;
    end
    else
    begin
      RDATA_OUT <= rdata_next;
    end
  end

  // --------------------------------------------------------------
  // Interrupt requests
  // --------------------------------------------------------------
  assign OVERFLOW_IRQ_OUT   = ovf_flag_reg & ctrl_reg[`PACC_CTRL_OVF_IE];
  assign INPUT_EDGE_IRQ_OUT = in_flag_reg & ctrl_reg[`PACC_CTRL_IN_IE];

endmodule

// ==== tb/pacc_top_asserts.sv ====
// Port-level checks for the pulse accumulator
`include "pacc_consts.vh"
module pacc_top_asserts
#(
  parameter CNT_W = 16
)
(
  input wire                    SYS_CLK_IN,
  input wire                    RST_N_IN,
  input wire [`PACC_ADDR_W-1:0] ADDR_IN,
  input wire [7:0]              WDATA_IN,
  input wire                    WR_IN,
  input wire                    RD_IN,
  input wire                    WORD_IN,
  input wire [15:0]             RDATA_OUT,
  input wire                    CHANNEL_SEVEN_PIN_IN,
  input wire                    MAIN_TIMER_ENABLE_IN,
  input wire                    FAST_FLAG_CLEAR_IN,
  input wire                    PRESCALER_TICK_IN,
  input wire                    PRESCALER_DIV64_TICK_IN,
  input wire                    TIMER_COUNTER_TICK_OUT,
  input wire                    PULSE_COUNTER_CLOCK_OUT,
  input wire                    OVERFLOW_IRQ_OUT,
  input wire                    INPUT_EDGE_IRQ_OUT
);
  // ----------------------------------------
  // Control shadow and pin stability count
  // ----------------------------------------
  logic [7:0] ctl_reg;
  logic [2:0] stab_reg;
  logic       pin_reg;
  logic [15:0] pk_reg;
  wire        ctl_en = ctl_reg[6];
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  always @(posedge SYS_CLK_IN)
  begin
    pin_reg <= CHANNEL_SEVEN_PIN_IN;
    if (!RST_N_IN)
      ctl_reg <= 8'h00;
    else if (WR_IN && ADDR_IN == 6'h20)
      ctl_reg <= WDATA_IN;
    if (!RST_N_IN || CHANNEL_SEVEN_PIN_IN != pin_reg)
      stab_reg <= 3'h0;
    else if (stab_reg != 3'h7)
      stab_reg <= stab_reg + 3'h1;
    if (!RST_N_IN)
      pk_reg <= 16'h0000;
    else if (PULSE_COUNTER_CLOCK_OUT)
      pk_reg <= pk_reg + 16'h0001;
  end
  a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
    else $error("read data outside read slot");
  a_ctrl_readback: assert property (RD_IN && ADDR_IN == 6'h20 |=> RDATA_OUT == {9'h0, ctl_reg[6:0]})
    else $error("control readback wrong");
  a_prescale_forced: assert property (!ctl_en |-> TIMER_COUNTER_TICK_OUT == PRESCALER_TICK_IN)
    else $error("timer tick not prescaler");
  a_pulse_source: assert property (ctl_en && ctl_reg[3:2] == 2'h1 |-> TIMER_COUNTER_TICK_OUT == PULSE_COUNTER_CLOCK_OUT)
    else $error("timer tick not pulse clock");
  a_disabled_quiet: assert property (!ctl_en |-> !PULSE_COUNTER_CLOCK_OUT)
    else $error("count tick while disabled");
  a_gate_tick: assert property (ctl_en && ctl_reg[5] && !(PRESCALER_DIV64_TICK_IN && MAIN_TIMER_ENABLE_IN) |-> !PULSE_COUNTER_CLOCK_OUT)
    else $error("gated tick without div64 tick");
  a_event_stable: assert property (ctl_en && !ctl_reg[5] && stab_reg == 3'h7 |-> !PULSE_COUNTER_CLOCK_OUT)
    else $error("event tick without pin edge");
  a_ovf_irq: assert property (OVERFLOW_IRQ_OUT |-> ctl_reg[1])
    else $error("overflow request while masked");
  a_in_irq: assert property (INPUT_EDGE_IRQ_OUT |-> ctl_reg[0])
    else $error("input request while masked");
  a_flag_clear: assert property (WR_IN && ADDR_IN == 6'h21 && WDATA_IN[0] && (ctl_en || MAIN_TIMER_ENABLE_IN) && !ctl_reg[5] && !PULSE_COUNTER_CLOCK_OUT |=> !INPUT_EDGE_IRQ_OUT)
    else $error("input flag not cleared");
  a_fast_clear: assert property (FAST_FLAG_CLEAR_IN && (RD_IN || WR_IN) && ADDR_IN[5:1] == 5'h11 && !PULSE_COUNTER_CLOCK_OUT |=> !OVERFLOW_IRQ_OUT)
    else $error("fast clear missed overflow flag");
  a_div256_source: assert property (ctl_en && ctl_reg[3:2] == 2'h2 |->
    TIMER_COUNTER_TICK_OUT == (PULSE_COUNTER_CLOCK_OUT && pk_reg[7:0] == 8'hff))
    else $error("timer tick not pulse clock over 256");
  a_div64k_source: assert property (ctl_en && ctl_reg[3:2] == 2'h3 |->
    TIMER_COUNTER_TICK_OUT == (PULSE_COUNTER_CLOCK_OUT && pk_reg == 16'hffff))
    else $error("timer tick not pulse clock over 65536");
endmodule

// ==== tb/pacc_pin_model.sv ====
// Far-side model driving pulse trains on the shared pin
module pacc_pin_model
(
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic [7:0] pulses_in,
  input  wire logic [7:0] half_in,
  output logic            pin_out,
  output logic            busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pin_out = 1'b0;
    busy_out = 1'b0;
    forever
    begin
      @(posedge clk_in);
      if (start_in)
      begin
        busy_out <= 1'b1;
        repeat (pulses_in)
        begin
          pin_out <= 1'b1;
          repeat (half_in) @(posedge clk_in);
          pin_out <= 1'b0;
          repeat (half_in) @(posedge clk_in);
        end
        busy_out <= 1'b0;
      end
    end
  end
endmodule

// ==== tb/pacc_test.sv ====
// Self-checking bench for the pulse accumulator
module pacc_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, word = 0, mte = 0, fast = 0, presc = 0, d64 = 0;
  logic start = 0, pin, busy;
  logic [5:0] addr = 0, ph = 0;
  logic [7:0] wdata = 0, half = 4, npul = 0;
  logic [15:0] rdata, cnt, r, fl;
  logic [15:0] pk = 0;
  wire tick, pclk, ovf_irq, in_irq;
  integer error_cnt = 0, compares = 0, seed = 27125, i, k, t0, nt = 0;
  pacc_top pacc_top_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .WORD_IN(word), .RDATA_OUT(rdata), .CHANNEL_SEVEN_PIN_IN(pin),
    .MAIN_TIMER_ENABLE_IN(mte), .FAST_FLAG_CLEAR_IN(fast), .PRESCALER_TICK_IN(presc),
    .PRESCALER_DIV64_TICK_IN(d64), .TIMER_COUNTER_TICK_OUT(tick),
    .PULSE_COUNTER_CLOCK_OUT(pclk), .OVERFLOW_IRQ_OUT(ovf_irq), .INPUT_EDGE_IRQ_OUT(in_irq));
  pacc_pin_model pacc_pin_model_i (.clk_in(clk), .start_in(start), .pulses_in(npul),
    .half_in(half), .pin_out(pin), .busy_out(busy));
  // ----------------------------------------
  // Clock, prescaler ticks and helpers
  // ----------------------------------------
  initial
  begin
    forever #25 clk = ~clk;
  end
  function automatic logic [15:0] rnd16();
    rnd16 = 16'($random(seed));
  endfunction
  function automatic logic wraps(input logic [15:0] c, input logic [4:0] n);
    wraps = ({1'b0, c} + n) > 17'h0ffff;
  endfunction
  always @(posedge clk)
  begin
    presc <= ^rnd16();
    ph <= ph + 6'h01;
    d64 <= (ph == 6'h3f);
    if (pclk)
      pk <= pk + 16'h0001;
    if (tick)
      nt <= nt + 1;
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    word <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    word <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic w, input logic [15:0] exp, input string s);
    @(posedge clk);
    addr <= a;
    word <= w;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    word <= 1'b0;
    #1;
    chk(s, rdata, exp);
  endtask
  task automatic set_cnt(input logic [15:0] v);
    wr_reg(6'h22, v[15:8], 1'b1);
    wr_reg(6'h23, v[7:0], 1'b0);
  endtask
  task automatic pulses(input logic [7:0] n, h);
    @(posedge clk);
    npul <= n;
    half <= h;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (k = 0; busy && k < 9999; k++) @(posedge clk);
    chk("pulse wait", {15'h0, busy}, 16'h0000);
    if (busy)
      report_and_stop();
    repeat (5) @(posedge clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(6'h20, 1'b0, 16'h0000, "ctrl reset");
    rchk(6'h22, 1'b1, 16'h0000, "count reset");
    rchk(6'h30, 1'b0, 16'h0000, "unmapped");
    for (i = 0; i < 8; i++)
    begin
      r = rnd16();
      cnt = (i == 0) ? 16'hfffe : rnd16();
      mte <= r[15];
      wr_reg(6'h20, {3'h2, r[4:2], 2'h3}, 1'b0);
      set_cnt(cnt);
      wr_reg(6'h21, 8'h03, 1'b0);
      pulses({4'h0, r[11:8]} + 8'h01, 8'h04);
      fl = {14'h0, wraps(cnt, {1'b0, r[11:8]} + 5'h01), 1'b1};
      rchk(6'h22, 1'b1, cnt + {12'h0, r[11:8]} + 16'h1, "event count");
      rchk(6'h21, 1'b0, fl, "event flags");
      chk("irq pair", {14'h0, ovf_irq, in_irq}, fl);
    end
    wr_reg(6'h20, 8'h00, 1'b0);
    mte <= 1'b0;
    wr_reg(6'h21, 8'h03, 1'b0);
    rchk(6'h21, 1'b0, fl, "clear refused");
    mte <= 1'b1;
    wr_reg(6'h21, 8'h03, 1'b0);
    rchk(6'h21, 1'b0, 16'h0000, "clear by timer");
    wr_reg(6'h20, 8'h43, 1'b0);
    set_cnt(16'hffff);
    pulses(8'h01, 8'h04);
    chk("wrap irq", {15'h0, ovf_irq}, 16'h0001);
    fast <= 1'b1;
    rchk(6'h23, 1'b0, 16'h0000, "wrapped low");
    rchk(6'h21, 1'b0, 16'h0000, "fast clear");
    fast <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      mte <= i[0];
      wr_reg(6'h20, 8'h60, 1'b0);
      set_cnt(16'h0000);
      wr_reg(6'h21, 8'h03, 1'b0);
      for (k = 0; ph != 6'h0a && k < 99; k++) @(posedge clk);
      pulses(8'h01, 8'hc0);
      rchk(6'h22, 1'b1, i ? 16'h0003 : 16'h0000, "gated count");
      rchk(6'h21, 1'b0, 16'h0001, "gate trail flag");
    end
    wr_reg(6'h20, 8'h48, 1'b0);
    cnt = pk;
    t0 = nt;
    pulses(8'hff, 8'h01);
    pulses(8'hff, 8'h01);
    rchk(6'h22, 1'b1, 16'h0201, "long train count");
    chk("div256 ticks", nt[15:0] - t0[15:0], {8'h0, pk[15:8]} - {8'h0, cnt[15:8]});
    report_and_stop();
  end
endmodule
bind pacc_top pacc_top_asserts #(.CNT_W(CNT_W)) pacc_top_asserts_i (.SYS_CLK_IN(SYS_CLK_IN),
  .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .WORD_IN(WORD_IN), .RDATA_OUT(RDATA_OUT), .CHANNEL_SEVEN_PIN_IN(CHANNEL_SEVEN_PIN_IN),
  .MAIN_TIMER_ENABLE_IN(MAIN_TIMER_ENABLE_IN), .FAST_FLAG_CLEAR_IN(FAST_FLAG_CLEAR_IN),
  .PRESCALER_TICK_IN(PRESCALER_TICK_IN), .PRESCALER_DIV64_TICK_IN(PRESCALER_DIV64_TICK_IN),
  .TIMER_COUNTER_TICK_OUT(TIMER_COUNTER_TICK_OUT),
  .PULSE_COUNTER_CLOCK_OUT(PULSE_COUNTER_CLOCK_OUT), .OVERFLOW_IRQ_OUT(OVERFLOW_IRQ_OUT),
  .INPUT_EDGE_IRQ_OUT(INPUT_EDGE_IRQ_OUT));
